// *** sdram_cmd_map.vh ***
/*
 * Constants for the synchronous DRAM command interface: command codes,
 * mode field positions, geometry and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SDRAM_CMD_MAP_VH
`define SDRAM_CMD_MAP_VH

// -----------------------------------------------------------------
// Command codes {chip_sel_n, row_strobe_n, col_strobe_n, write_sel_n}
// -----------------------------------------------------------------
`define CMD_ROW_OPEN      4'h3
`define CMD_ROW_CLOSE     4'h2
`define CMD_READ          4'h5
`define CMD_WRITE         4'h4
`define CMD_MODE_SET      4'h0
`define CMD_AUTO_REFRESH  4'h1
`define CMD_BURST_STOP    4'h6
`define CMD_NOP           4'h7

// -----------------------------------------------------------------
// Mode op-code fields on the address lines
// -----------------------------------------------------------------
`define MODE_BL_LSB       0
`define MODE_BL_MSB       2
`define MODE_BT_BIT       3
`define MODE_CL_LSB       4
`define MODE_CL_MSB       6
`define MODE_RESET        11'h022
`define BL_ONE            3'h0
`define BL_TWO            3'h1
`define BL_FOUR           3'h2
`define BL_EIGHT          3'h3
`define BL_PAGE           3'h7

// -----------------------------------------------------------------
// Geometry and timing
// -----------------------------------------------------------------
`define ROW_BITS          11
`define COL_BITS          8
`define PRECHARGE_NS      20
`define CLK_PERIOD_NS     4
`define PRECHARGE_CYCLES  ((`PRECHARGE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MASK_LATENCY      2
`define PIPE_DEPTH        4

`endif

// *** sdram_pin_sync.v ***
/*
 * Three-flop synchroniser for one level that comes from a pin.
 * Assumes the input may change at any time relative to clk.
 */
`timescale 1ns/100ps
`default_nettype none

module sdram_pin_sync #(
	parameter RESET_VAL = 1'b0
) (
	input  wire clk,
	input  wire rst,
	input  wire pin,
	output reg  level_q
);

	reg s1_q;
	reg s2_q;
	reg s3_q;

	// -----------------------------------------------------------------
	// A change counts once the second and third flops agree.
	// -----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			s1_q    <= RESET_VAL;
			s2_q    <= RESET_VAL;
			s3_q    <= RESET_VAL;
			level_q <= RESET_VAL;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end

endmodule // sdram_pin_sync

`default_nettype wire

// *** sdram_command_interface.v ***
/*
 * Command decoder, bank state and burst engine of a two-bank 16-bit
 * synchronous DRAM, sampled on the rising edge of clk.
 * Assumes the controller pins are already in the clk domain, except the
 * clock-gate pin, which is synchronised here; the array lives outside.
 */
`timescale 1ns/100ps
`default_nettype none
`include "sdram_cmd_map.vh"

// Functional notes
// RULE1: sample all inputs on rising clock only
// RULE2: each edge advances burst counter, output registers
// RULE3: clock-gate low freezes outputs and burst address
// RULE4: power-down entry only with both banks idle
// RULE5: in low-power mode gate treated asynchronously
// RULE6: bank select picks target bank
// RULE7: row on activate, column on access
// RULE8: precharge flag high closes both banks
// RULE9: mode set loads mode register from address
// RULE10: chip-select high masks every command
// RULE11: activate opens selected bank
// RULE12: precharge returns bank idle after completion
// RULE13: column access starts read or write
// RULE14: write-select low write, high read
// RULE15: column access needs open row first
// RULE16: bursts 1,2,4,8,page with early stop
// RULE17: read latency one to three cycles
// RULE18: interleaved or sequential burst ordering
// RULE19: auto-precharge at burst end
// RULE20: banks are 2048 rows by 256 columns
// RULE21: controller keeps refresh schedule
// RULE22: byte masks: writes immediate, reads two clocks
module sdram_command_interface #(
	parameter PRECHARGE_CYCLES = `PRECHARGE_CYCLES
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        clock_gate,
	input  wire        chip_sel_n,
	input  wire        row_strobe_n,
	input  wire        col_strobe_n,
	input  wire        write_sel_n,
	input  wire        bank_select_line,
	input  wire [10:0] address_lines,
	input  wire        lower_byte_mask,
	input  wire        upper_byte_mask,
	output reg         array_en_q,
	output reg         array_write_q,
	output reg         array_bank_q,
	output reg  [10:0] array_row_q,
	output reg  [7:0]  array_col_q,
	output reg  [1:0]  write_lane_en_q,
	output reg         read_valid_q,
	output reg  [1:0]  read_lane_en_q,
	output reg  [1:0]  bank_open_q,
	output reg  [10:0] mode_q,
	output reg         low_power_q,
	output reg         refresh_req_q,
	output reg         cmd_error_q
);

	// -----------------------------------------------------------------
	// Bank states and working registers
	// -----------------------------------------------------------------
	localparam BANK_IDLE   = 2'h0;
	localparam BANK_ACTIVE = 2'h1;
	localparam BANK_PRECH  = 2'h2;

	wire       gate_level;
	reg        gate_prev_q;
	reg  [1:0] bank_state_q [0:1];
	reg  [10:0] row_q [0:1];
	reg  [7:0] pch_cnt_q [0:1];
	reg        burst_act_q;
	reg        burst_write_q;
	reg        burst_bank_q;
	reg        burst_auto_q;
	reg  [7:0] burst_start_q;
	reg  [7:0] burst_idx_q;
	reg  [8:0] burst_left_q;
	reg  [`PIPE_DEPTH-1:0] rd_pipe_q;
	reg  [1:0] mask_d1_q;
	reg  [1:0] mask_d2_q;
	reg  [8:0] burst_len;
	reg  [7:0] burst_col;
	reg  [1:0] cl_sel;
	integer    b;

	// -----------------------------------------------------------------
	// Command word and decode helpers
	// -----------------------------------------------------------------
	wire [3:0] cmd = {chip_sel_n, row_strobe_n, col_strobe_n, write_sel_n};
	// Suspension starts one cycle after the synchronised gate is seen low.
	wire       run = gate_prev_q;
	wire [1:0] mask_now = {upper_byte_mask, lower_byte_mask};
	wire       both_idle = (bank_state_q[0] == BANK_IDLE) && (bank_state_q[1] == BANK_IDLE);
	wire       acc_ok = (bank_state_q[bank_select_line] == BANK_ACTIVE);
	// Read-pipe tap for the programmed latency; a latency code of zero is not a legal setting.
	wire [1:0] rd_tap = cl_sel - 2'h1;

	// -----------------------------------------------------------------
	// Clock-gate pin synchroniser
	// -----------------------------------------------------------------
	sdram_pin_sync #(
		.RESET_VAL (1'b1)
	) u_gate_sync (
		.clk     (clk),
		.rst     (rst),
		.pin     (clock_gate),
		.level_q (gate_level)
	); // [RULE5]

	// -----------------------------------------------------------------
	// Burst length and address order
	// -----------------------------------------------------------------
	always @* begin
		case (mode_q[`MODE_BL_MSB:`MODE_BL_LSB])
			`BL_ONE:   burst_len = 9'h001;
			`BL_TWO:   burst_len = 9'h002;
			`BL_FOUR:  burst_len = 9'h004;
			`BL_EIGHT: burst_len = 9'h008;
			`BL_PAGE:  burst_len = 9'h100;
			default:   burst_len = 9'h001;
		endcase // [RULE16]
		cl_sel = mode_q[`MODE_CL_LSB+1:`MODE_CL_LSB];
		// A full page always counts upward; interleave applies to short bursts only.
		if (mode_q[`MODE_BT_BIT] && (burst_len != 9'h100)) begin
			burst_col = burst_start_q ^ (burst_idx_q & (burst_len[7:0] - 8'h01)); // [RULE18]
		end else begin
			burst_col = (burst_start_q & ~(burst_len[7:0] - 8'h01))
				| ((burst_start_q + burst_idx_q) & (burst_len[7:0] - 8'h01)); // [RULE18]
		end
	end

	// -----------------------------------------------------------------
	// Command decode, bank state and burst engine
	// -----------------------------------------------------------------
	always @(posedge clk) begin // [RULE1]
		if (rst) begin
			gate_prev_q     <= 1'b1;
			burst_act_q     <= 1'b0;
			burst_write_q   <= 1'b0;
			burst_bank_q    <= 1'b0;
			burst_auto_q    <= 1'b0;
			burst_start_q   <= 8'h00;
			burst_idx_q     <= 8'h00;
			burst_left_q    <= 9'h000;
			rd_pipe_q       <= {`PIPE_DEPTH{1'b0}};
			mask_d1_q       <= 2'h0;
			mask_d2_q       <= 2'h0;
			array_en_q      <= 1'b0;
			array_write_q   <= 1'b0;
			array_bank_q    <= 1'b0;
			array_row_q     <= 11'h000;
			array_col_q     <= 8'h00;
			write_lane_en_q <= 2'h0;
			read_valid_q    <= 1'b0;
			read_lane_en_q  <= 2'h0;
			bank_open_q     <= 2'h0;
			mode_q          <= `MODE_RESET;
			low_power_q     <= 1'b0;
			refresh_req_q   <= 1'b0;
			cmd_error_q     <= 1'b0;
			for (b = 0; b < 2; b = b + 1) begin
				bank_state_q[b] <= BANK_IDLE;
				row_q[b]        <= 11'h000;
				pch_cnt_q[b]    <= 8'h00;
			end
		end else begin
			gate_prev_q <= gate_level; // [RULE3]
			if (low_power_q) begin
				// Inputs ignored until the gate rises again; the entry pulse ends here.
				refresh_req_q <= 1'b0;
				if (gate_level) begin
					low_power_q <= 1'b0; // [RULE5]
				end
			end else if (!run) begin
				// Suspended cycle: state holds, but one-cycle pulses must not repeat.
				array_en_q    <= 1'b0; // [RULE3]
				refresh_req_q <= 1'b0;
				cmd_error_q   <= 1'b0;
			end else begin
				array_en_q    <= 1'b0;
				refresh_req_q <= 1'b0;
				cmd_error_q   <= 1'b0;
				// A low gate with both banks idle, no burst and a NOP, deselect or refresh enters low power; otherwise it only suspends.
				if (!gate_level && both_idle && !burst_act_q && (cmd == `CMD_NOP || chip_sel_n
					|| cmd == `CMD_AUTO_REFRESH)) begin
					low_power_q   <= 1'b1; // [RULE4]
					refresh_req_q <= (cmd == `CMD_AUTO_REFRESH);
				end
				// Precharge timers count down; a bank may be opened again once its timer ends.
				for (b = 0; b < 2; b = b + 1) begin
					if (bank_state_q[b] == BANK_PRECH) begin
						if (pch_cnt_q[b] <= 8'h01) begin
							bank_state_q[b] <= BANK_IDLE; // [RULE12]
						end
						pch_cnt_q[b] <= pch_cnt_q[b] - 8'h01;
					end
				end
				rd_pipe_q <= {rd_pipe_q[`PIPE_DEPTH-2:0], 1'b0};
				mask_d1_q <= mask_now;
				mask_d2_q <= mask_d1_q;
				// Read data leaves CL cycles after its array access.
				read_valid_q   <= rd_pipe_q[rd_tap]; // [RULE17]
				read_lane_en_q <= rd_pipe_q[rd_tap] ? ~mask_d2_q : 2'h0; // [RULE22]
				write_lane_en_q <= 2'h0;
				if (burst_act_q) begin
					array_en_q      <= 1'b1; // [RULE2]
					array_write_q   <= burst_write_q;
					array_bank_q    <= burst_bank_q;
					array_row_q     <= row_q[burst_bank_q];
					array_col_q     <= burst_col;
					write_lane_en_q <= burst_write_q ? ~mask_now : 2'h0; // [RULE22]
					rd_pipe_q[0]    <= ~burst_write_q;
					burst_idx_q     <= burst_idx_q + 8'h01; // [RULE2]
					burst_left_q    <= burst_left_q - 9'h001;
					if (burst_left_q == 9'h001) begin
						burst_act_q <= 1'b0;
						// Self-timed precharge starts with the last word of the burst.
						if (burst_auto_q) begin
							bank_state_q[burst_bank_q] <= BANK_PRECH; // [RULE19]
							pch_cnt_q[burst_bank_q]    <= PRECHARGE_CYCLES[7:0];
							bank_open_q[burst_bank_q]  <= 1'b0;
						end
					end
				end
				if (!chip_sel_n) begin // [RULE10]
					case (cmd)
						`CMD_ROW_OPEN: begin
							if (bank_state_q[bank_select_line] == BANK_IDLE) begin
								bank_state_q[bank_select_line] <= BANK_ACTIVE; // [RULE11] [RULE6]
								row_q[bank_select_line]        <= address_lines; // [RULE7] [RULE20]
								bank_open_q[bank_select_line]  <= 1'b1;
							end else begin
								// An activate to a bank that is not idle is refused.
								cmd_error_q <= 1'b1;
							end
						end
						`CMD_ROW_CLOSE: begin
							for (b = 0; b < 2; b = b + 1) begin
								if ((address_lines[10] || bank_select_line == b[0])
									&& bank_state_q[b] == BANK_ACTIVE) begin
									bank_state_q[b] <= BANK_PRECH; // [RULE8] [RULE12]
									pch_cnt_q[b]    <= PRECHARGE_CYCLES[7:0];
									bank_open_q[b]  <= 1'b0;
								end
							end
							// Closing the bank of a running burst also ends that burst.
							if (burst_act_q && (address_lines[10] || bank_select_line == burst_bank_q)) begin
								burst_act_q <= 1'b0; // [RULE16]
							end
						end
						`CMD_READ, `CMD_WRITE: begin
							if (acc_ok) begin // [RULE15] [RULE13]
								burst_act_q   <= 1'b1;
								burst_write_q <= ~write_sel_n; // [RULE14]
								burst_bank_q  <= bank_select_line; // [RULE6]
								burst_auto_q  <= address_lines[10]; // [RULE19]
								burst_start_q <= address_lines[7:0]; // [RULE7]
								burst_idx_q   <= 8'h00;
								burst_left_q  <= burst_len;
							end else begin
								cmd_error_q <= 1'b1;
							end
						end
						`CMD_MODE_SET: begin
							// A new mode mid-burst would corrupt the running address order.
							if (both_idle && !burst_act_q) begin
								mode_q <= address_lines; // [RULE9]
							end else begin
								cmd_error_q <= 1'b1;
							end
						end
						`CMD_AUTO_REFRESH: begin
							if (gate_level && both_idle) begin
								refresh_req_q <= 1'b1;
							end
						end
						`CMD_BURST_STOP: begin
							// The word launched on this edge is the last one of the burst.
							burst_act_q <= 1'b0; // [RULE16]
						end
						default: begin
						end
					endcase
				end
			end
		end
	end

endmodule // sdram_command_interface

`default_nettype wire

// *** sdram_cmd_sva.sv ***
/* Checker for the DRAM command interface.
   Bound to the design top; sees its ports only. */
`timescale 1ns/100ps
`default_nettype none
`include "sdram_cmd_map.vh"
module sdram_cmd_sva #(
	parameter PRECHARGE_CYCLES = 5
) (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        clock_gate,
	input wire logic        chip_sel_n,
	input wire logic        row_strobe_n,
	input wire logic        col_strobe_n,
	input wire logic        write_sel_n,
	input wire logic        bank_select_line,
	input wire logic [10:0] address_lines,
	input wire logic        lower_byte_mask,
	input wire logic        upper_byte_mask,
	input wire logic        array_en_q,
	input wire logic        array_write_q,
	input wire logic        array_bank_q,
	input wire logic [7:0]  array_col_q,
	input wire logic [1:0]  write_lane_en_q,
	input wire logic        read_valid_q,
	input wire logic [1:0]  read_lane_en_q,
	input wire logic [1:0]  bank_open_q,
	input wire logic [10:0] mode_q,
	input wire logic        low_power_q,
	input wire logic        refresh_req_q,
	input wire logic        cmd_error_q
);
	localparam int PC_MAX = PRECHARGE_CYCLES + 3;
	wire [3:0] cmd      = {chip_sel_n, row_strobe_n, col_strobe_n, write_sel_n};
	wire [7:0] col_in   = address_lines[7:0];
	wire [1:0] mask_in  = {upper_byte_mask, lower_byte_mask};
	wire       access   = cmd == `CMD_READ || cmd == `CMD_WRITE;
	wire       open_sel = bank_open_q[bank_select_line];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// The gate pin passes a synchroniser, so only a long high run is surely in effect.
	sequence gate_run;
		clock_gate [*6];
	endsequence
	sequence taken_access;
		gate_run ##0 access && open_sel;
	endsequence
	chk_deselect_quiet: assert property (chip_sel_n |=> !cmd_error_q)
		else $error("error after deselect");
	chk_open_bank: assert property (gate_run ##0 cmd == `CMD_ROW_OPEN && !open_sel
		|=> bank_open_q[$past(bank_select_line)])
		else $error("bank not opened");
	chk_idle_access: assert property (gate_run ##0 access && !open_sel |=> cmd_error_q)
		else $error("access to idle bank accepted");
	chk_first_word: assert property (taken_access |-> ##2 array_en_q && array_col_q == $past(col_in, 2)
		&& array_bank_q == $past(bank_select_line, 2) && array_write_q == !$past(write_sel_n, 2))
		else $error("first word wrong");
	chk_suspend_hold: assert property (!clock_gate [*7] |-> $stable(array_col_q))
		else $error("burst moved while suspended");
	chk_close_all: assert property (gate_run ##0 cmd == `CMD_ROW_CLOSE && address_lines[10]
		|-> ##[1:PC_MAX] bank_open_q == 2'b00)
		else $error("banks open after close-all");
	chk_read_late: assert property (array_en_q && !array_write_q && mode_q[5:4] == 2'd3 |-> ##3 read_valid_q)
		else $error("read latency missed");
	chk_read_mask: assert property (read_valid_q && $past(mask_in, 2) == $past(mask_in, 3)
		|-> read_lane_en_q == ~$past(mask_in, 2))
		else $error("read lane mask wrong");
	chk_write_mask: assert property (array_en_q && array_write_q |-> write_lane_en_q == ~$past(mask_in))
		else $error("write lane mask wrong");
	chk_idle_entry: assert property ($rose(low_power_q) |-> $past(bank_open_q) == 2'b00)
		else $error("low power entered with a bank open");
	chk_refresh_pulse: assert property (refresh_req_q |=> !refresh_req_q)
		else $error("refresh request held");
endmodule // sdram_cmd_sva
bind sdram_command_interface sdram_cmd_sva #(.PRECHARGE_CYCLES(PRECHARGE_CYCLES)) chk_u (
	.clk              (clk),
	.rst              (rst),
	.clock_gate       (clock_gate),
	.chip_sel_n       (chip_sel_n),
	.row_strobe_n     (row_strobe_n),
	.col_strobe_n     (col_strobe_n),
	.write_sel_n      (write_sel_n),
	.bank_select_line (bank_select_line),
	.address_lines    (address_lines),
	.lower_byte_mask  (lower_byte_mask),
	.upper_byte_mask  (upper_byte_mask),
	.array_en_q       (array_en_q),
	.array_write_q    (array_write_q),
	.array_bank_q     (array_bank_q),
	.array_col_q      (array_col_q),
	.write_lane_en_q  (write_lane_en_q),
	.read_valid_q     (read_valid_q),
	.read_lane_en_q   (read_lane_en_q),
	.bank_open_q      (bank_open_q),
	.mode_q           (mode_q),
	.low_power_q      (low_power_q),
	.refresh_req_q    (refresh_req_q),
	.cmd_error_q      (cmd_error_q)
);
`default_nettype wire

// *** ctl_model.sv ***
/* Controller model: turns one-cycle requests into command pin levels.
   Assumes requests change just after a rising clock edge. */
`timescale 1ns/100ps
`default_nettype none
module ctl_model (
	input  wire logic        clk,
	input  wire logic        req,
	input  wire logic [3:0]  code,
	input  wire logic [11:0] bank_addr,
	output logic      [3:0]  strobe_n,
	output logic      [11:0] pins
);
	logic [11:0] last_q = 12'h000;
	always_ff @(posedge clk) if (req) last_q <= bank_addr;
	// Lines between commands show the inverse of the last address.
	assign strobe_n = req ? code : 4'hf;
	assign pins     = req ? bank_addr : ~last_q;
endmodule // ctl_model
`default_nettype wire

// *** tb_sdram_command_interface.sv ***
/* Bench for the DRAM command interface; array words are scored in order.
   Assumes design, model and checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`include "sdram_cmd_map.vh"
module tb_sdram_command_interface;
	localparam int PC = 2;
	logic        clk = 1'b0, rst = 1'b1, gate = 1'b1, req = 1'b0, lm = 1'b0, um = 1'b0, err_seen, ref_seen;
	logic [3:0]  code = 4'hf;
	logic [11:0] ba = 12'h000;
	logic [10:0] row;
	logic [7:0]  col;
	logic [20:0] expq[$];
	wire  [3:0]  sn;
	wire  [11:0] pins;
	wire         en, wr, ab, lp, rf, er;
	wire  [10:0] arow, mode;
	wire  [7:0]  acol;
	wire  [1:0]  bo;
	int          fail_count = 0, checked = 0;

	ctl_model ctl (.clk(clk), .req(req), .code(code), .bank_addr(ba), .strobe_n(sn), .pins(pins));
	sdram_command_interface #(.PRECHARGE_CYCLES(PC)) dut (.clk(clk), .rst(rst), .clock_gate(gate),
		.chip_sel_n(sn[3]), .row_strobe_n(sn[2]), .col_strobe_n(sn[1]), .write_sel_n(sn[0]),
		.bank_select_line(pins[11]), .address_lines(pins[10:0]), .lower_byte_mask(lm), .upper_byte_mask(um),
		.array_en_q(en), .array_write_q(wr), .array_bank_q(ab), .array_row_q(arow), .array_col_q(acol),
		.write_lane_en_q(), .read_valid_q(), .read_lane_en_q(), .bank_open_q(bo), .mode_q(mode),
		.low_power_q(lp), .refresh_req_q(rf), .cmd_error_q(er));

	initial forever #2 clk = ~clk;

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [20:0] got, input logic [20:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmd(input logic [3:0] c, input logic [11:0] a);
		@(posedge clk);
		code <= c;
		ba <= a;
		req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		#1;
		err_seen = er;
		ref_seen = rf;
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk);
			{um, lm} <= 2'($urandom);
		end
	endtask

	task automatic burst(input logic w, input logic b, input int n, input logic il);
		for (int i = 0; i < n; i++)
			expq.push_back({w, b, row, il ? col ^ 8'(i) : (col & 8'(~(n - 1))) | ((col + 8'(i)) & 8'(n - 1))});
	endtask

	task automatic drain;
		for (int i = 0; i < 60 && expq.size() > 0; i++)
			idle(1);
		if (expq.size() > 0) begin
			fail_count++;
			stop_test;
		end
	endtask

	always @(posedge clk)
		if (en === 1'b1)
			chk({wr, ab, arow, acol}, expq.size() > 0 ? expq.pop_front() : 21'hx);

	initial begin
		void'($urandom(29445));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk(21'({bo, mode}), 21'h000022);
		idle(6); // Lets the checker see a full gate history before the first command.
		cmd(4'hb, 12'h123);
		chk(21'({err_seen, bo}), 21'h0);
		cmd(`CMD_READ, 12'h000);
		chk(21'(err_seen), 21'h1);
		{row, col} = 19'($urandom);
		cmd(`CMD_ROW_OPEN, {1'b1, row});
		chk(21'(bo), 21'h2);
		burst(1'b1, 1'b1, 4, 1'b0);
		@(posedge clk);
		gate <= 1'b0;
		cmd(`CMD_WRITE, {4'h8, col});
		idle(7);
		gate <= 1'b1;
		drain;
		idle(4);
		cmd(`CMD_ROW_CLOSE, 12'h400);
		idle(PC + 3);
		#1;
		chk(21'(bo), 21'h0);
		cmd(`CMD_MODE_SET, 12'h03b);
		chk(21'(mode), 21'h03b);
		cmd(`CMD_AUTO_REFRESH, 12'h000);
		chk(21'(ref_seen), 21'h1);
		{row, col} = 19'($urandom);
		cmd(`CMD_ROW_OPEN, {1'b0, row});
		chk(21'(bo), 21'h1);
		burst(1'b0, 1'b0, 8, 1'b1);
		cmd(`CMD_READ, {4'h4, col});
		drain;
		idle(PC + 6);
		#1;
		chk(21'(bo), 21'h0);
		@(posedge clk);
		gate <= 1'b0; // Both banks are idle here.
		idle(8);
		cmd(`CMD_ROW_OPEN, {1'b1, row});
		chk(21'({lp, bo}), 21'h4);
		@(posedge clk);
		gate <= 1'b1;
		for (int i = 0; i < 20 && lp !== 1'b0; i++)
			idle(1);
		chk(21'(lp), 21'h0);
		chk(21'(expq.size()), 21'h0);
		stop_test;
	end
endmodule // tb_sdram_command_interface
`default_nettype wire
